// >>> verilog/ppcs_top.sv
// Polarity, clock source and per-channel waveform logic behind an AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
module ppcs_top #(
  parameter int NCH = ppcs_pkg::NUM_CH
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  input  wire logic        first_scaled_clock,
  input  wire logic        second_scaled_clock,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [5:0]  pwm_out
);
  typedef logic [ppcs_pkg::CNT_W-1:0] ppcs_cnt_t;

  logic [5:0]  channel_polarity_reg, channel_polarity_next;
  logic [5:0]  channel_clock_source_reg, channel_clock_source_next;
  logic [5:0]  channel_enable_reg, channel_enable_next;
  logic [6:0]  rates_reg, rates_next;
  ppcs_cnt_t   period_reg [NCH];
  ppcs_cnt_t   period_next [NCH];
  ppcs_cnt_t   duty_reg [NCH];
  ppcs_cnt_t   duty_next [NCH];
  ppcs_cnt_t   count_reg [NCH];
  ppcs_cnt_t   count_next [NCH];
  logic [5:0]  running_reg, running_next;
  logic [5:0]  pwm_reg, pwm_next;
  logic [6:0]  pre_reg, pre_next;
  logic [6:0]  pre_prev_reg;
  logic [2:0]  sa_sync_reg, sb_sync_reg;
  logic        tick_a, tick_b, tick_sa, tick_sb;
  logic        sa_level_reg, sa_level_next;
  logic        sb_level_reg, sb_level_next;
  logic [5:0]  ch_tick;
  logic [31:0] rdata_reg, rdata_next;
  ppcs_pkg::ppcs_req_t req_reg, req_next;

  // Prescaled tick: rising edge of divider bit for rate 1..7, every cycle for rate 0
  function automatic logic pre_tick(input logic [2:0] rate, input logic [6:0] cur,
                                    input logic [6:0] prev);
    if (rate == 3'h0)
      pre_tick = 1'b1;
    else
      pre_tick = cur[rate-3'h1] & ~prev[rate-3'h1];
  endfunction

  // Scaled clocks come from another divider; three flops, edge on agreeing pair
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sa_sync_reg  <= 3'h0;
      sb_sync_reg  <= 3'h0;
      sa_level_reg <= 1'b0;
      sb_level_reg <= 1'b0;
      pre_reg      <= ppcs_pkg::PRE_RESET;
      pre_prev_reg <= ppcs_pkg::PRE_RESET;
    end else begin
      sa_sync_reg  <= {sa_sync_reg[1:0], first_scaled_clock};
      sb_sync_reg  <= {sb_sync_reg[1:0], second_scaled_clock};
      sa_level_reg <= sa_level_next;
      sb_level_reg <= sb_level_next;
      pre_reg      <= pre_next;
      pre_prev_reg <= pre_reg;
    end
  end

  always_comb begin
    // Prescaler idles when no channel is enabled
    pre_next = (|channel_enable_reg) ? 7'(pre_reg + 7'h01) : ppcs_pkg::PRE_RESET;
    tick_a  = (|channel_enable_reg) &
              pre_tick(rates_reg[2:0], pre_reg, pre_prev_reg);
    tick_b  = (|channel_enable_reg) &
              pre_tick(rates_reg[6:4], pre_reg, pre_prev_reg);
    // Level follows the pin only once the last two flops agree
    sa_level_next = (sa_sync_reg[1] == sa_sync_reg[2]) ? sa_sync_reg[2] : sa_level_reg;
    sb_level_next = (sb_sync_reg[1] == sb_sync_reg[2]) ? sb_sync_reg[2] : sb_level_reg;
    tick_sa = sa_level_next & ~sa_level_reg;
    tick_sb = sb_level_next & ~sb_level_reg;
    for (int i = 0; i < NCH; i++) begin
      if (ppcs_pkg::SECOND_GROUP[i])
        ch_tick[i] = channel_clock_source_reg[i] ? tick_sb : tick_b;
      else
        ch_tick[i] = channel_clock_source_reg[i] ? tick_sa : tick_a;
    end
  end

  // Channel counters, left aligned
  always_comb begin
    running_next = running_reg;
    pwm_next     = pwm_reg;
    for (int i = 0; i < NCH; i++) begin
      count_next[i] = count_reg[i];
      if (!channel_enable_reg[i]) begin
        running_next[i] = 1'b0;
        count_next[i]   = '0;
        pwm_next[i]     = 1'b0;
      end else if (ch_tick[i]) begin
        running_next[i] = 1'b1;
        if (!running_reg[i] || count_reg[i] >= 8'(period_reg[i] - 8'h01))
          count_next[i] = '0;
        else
          count_next[i] = 8'(count_reg[i] + 8'h01);
      end
      if (running_next[i]) begin
        // Polarity applied live so a change acts at once
        if (count_next[i] < duty_reg[i])
          pwm_next[i] = channel_polarity_reg[i];
        else
          pwm_next[i] = ~channel_polarity_reg[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running_reg <= 6'h00;
      pwm_reg     <= 6'h00;
      for (int i = 0; i < NCH; i++) count_reg[i] <= '0;
    end else begin
      running_reg <= running_next;
      pwm_reg     <= pwm_next;
      for (int i = 0; i < NCH; i++) count_reg[i] <= count_next[i];
    end
  end

  // AHB-Lite slave: zero wait states
  always_comb begin
    logic [11:0] a;
    a = req_reg.addr;
    req_next.sel   = hsel & hready & (htrans == ppcs_pkg::HTRANS_NONSEQ);
    req_next.write = hwrite;
    req_next.addr  = haddr[11:0];
    channel_polarity_next     = channel_polarity_reg;
    channel_clock_source_next = channel_clock_source_reg;
    channel_enable_next       = channel_enable_reg;
    rates_next                = rates_reg;
    for (int i = 0; i < NCH; i++) begin
      period_next[i] = period_reg[i];
      duty_next[i]   = duty_reg[i];
    end
    if (req_reg.sel && req_reg.write) begin
      unique case (a)
        ppcs_pkg::ADDR_POLARITY:   channel_polarity_next = hwdata[5:0];
        ppcs_pkg::ADDR_CLK_SOURCE: channel_clock_source_next = hwdata[5:0];
        ppcs_pkg::ADDR_ENABLE:     channel_enable_next = hwdata[5:0];
        ppcs_pkg::ADDR_RATES:      rates_next = {hwdata[6:4], 1'b0, hwdata[2:0]};
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (a == 12'(ppcs_pkg::ADDR_PERIOD0 + 12'(4 * i)))
              period_next[i] = hwdata[7:0];
            if (a == 12'(ppcs_pkg::ADDR_DUTY0 + 12'(4 * i)))
              duty_next[i] = hwdata[7:0];
          end
        end
      endcase
    end
    rdata_next = 32'h0000_0000;
    if (req_next.sel && !hwrite) begin
      unique case (haddr[11:0])
        ppcs_pkg::ADDR_POLARITY:   rdata_next = {26'h0, channel_polarity_next};
        ppcs_pkg::ADDR_CLK_SOURCE: rdata_next = {26'h0, channel_clock_source_next};
        ppcs_pkg::ADDR_ENABLE:     rdata_next = {26'h0, channel_enable_next};
        ppcs_pkg::ADDR_RATES:      rdata_next = {25'h0, rates_next};
        ppcs_pkg::ADDR_STATUS:     rdata_next = {26'h0, running_next};
        default: begin
          for (int i = 0; i < NCH; i++) begin
            if (haddr[11:0] == 12'(ppcs_pkg::ADDR_PERIOD0 + 12'(4 * i)))
              rdata_next = {24'h0, period_next[i]};
            if (haddr[11:0] == 12'(ppcs_pkg::ADDR_DUTY0 + 12'(4 * i)))
              rdata_next = {24'h0, duty_next[i]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg                  <= '0;
      rdata_reg                <= 32'h0000_0000;
      channel_polarity_reg     <= 6'h00;
      channel_clock_source_reg <= 6'h00;
      channel_enable_reg       <= 6'h00;
      rates_reg                <= 7'h00;
      for (int i = 0; i < NCH; i++) begin
        period_reg[i] <= '0;
        duty_reg[i]   <= '0;
      end
    end else begin
      req_reg                  <= req_next;
      rdata_reg                <= rdata_next;
      channel_polarity_reg     <= channel_polarity_next;
      channel_clock_source_reg <= channel_clock_source_next;
      channel_enable_reg       <= channel_enable_next;
      rates_reg                <= rates_next;
      for (int i = 0; i < NCH; i++) begin
        period_reg[i] <= period_next[i];
        duty_reg[i]   <= duty_next[i];
      end
    end
  end

  always_comb begin
    hrdata    = rdata_reg;
    hreadyout = 1'b1;
    hresp     = 1'b0;
    pwm_out   = pwm_reg;
  end

  // Checks
  sequence s_period_start(int i);
    ch_tick[i] && running_reg[i] && channel_enable_reg[i];
  endsequence

  a_pol_high_start: assert property (@(posedge hclk) disable iff (!hresetn)
    (channel_enable_reg[0] && ch_tick[0] && !running_reg[0] && duty_reg[0] != 8'h00)
    |=> pwm_out[0] == $past(channel_polarity_reg[0]))
    else $error("channel 0 start level wrong");
  a_pol_low_duty: assert property (@(posedge hclk) disable iff (!hresetn)
    (running_reg[1] && count_reg[1] >= duty_reg[1] && $stable(duty_reg[1]))
    |-> pwm_out[1] == ~$past(channel_polarity_reg[1]))
    else $error("channel 1 level after duty wrong");
  a_src_first_grp: assert property (@(posedge hclk) disable iff (!hresetn)
    channel_clock_source_reg[0] |-> ch_tick[0] == tick_sa)
    else $error("channel 0 source wrong");
  a_src_second_grp: assert property (@(posedge hclk) disable iff (!hresetn)
    !channel_clock_source_reg[2] |-> ch_tick[2] == tick_b)
    else $error("channel 2 source wrong");
  a_src_bit_pos: assert property (@(posedge hclk) disable iff (!hresetn)
    channel_clock_source_reg[5] |-> ch_tick[5] == tick_sa)
    else $error("channel 5 source wrong");
  sequence s_rate1_tick;
    rates_reg[2:0] == 3'h1 && tick_a;
  endsequence

  sequence s_rate1_hold;
    rates_reg[2:0] == 3'h1 && (|channel_enable_reg);
  endsequence

  a_rate_div2: assert property (@(posedge hclk) disable iff (!hresetn)
    s_rate1_tick ##1 s_rate1_hold
    |-> !tick_a ##1 (tick_a || !(rates_reg[2:0] == 3'h1 && (|channel_enable_reg))))
    else $error("prescaler divide by two wrong");
  a_enable_waits: assert property (@(posedge hclk) disable iff (!hresetn)
    (!running_reg[3] && !ch_tick[3]) |=> !running_reg[3])
    else $error("channel 3 ran before its tick");
  a_pol_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (req_reg.sel && req_reg.write && req_reg.addr == ppcs_pkg::ADDR_POLARITY)
    |=> channel_polarity_reg == $past(hwdata[5:0]))
    else $error("polarity write lost");
  a_src_readback: assert property (@(posedge hclk) disable iff (!hresetn)
    (req_reg.sel && req_reg.write && req_reg.addr == ppcs_pkg::ADDR_CLK_SOURCE)
    |=> channel_clock_source_reg == $past(hwdata[5:0]))
    else $error("source write lost");
  a_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (req_reg.sel && !req_reg.write && (req_reg.addr == ppcs_pkg::ADDR_POLARITY ||
     req_reg.addr == ppcs_pkg::ADDR_CLK_SOURCE)) |-> hrdata[31:6] == 26'h0)
    else $error("upper read bits not zero");
  a_wrap_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    s_period_start(4) ##0 (count_reg[4] >= 8'(period_reg[4] - 8'h01) && duty_reg[4] != 8'h00)
    |=> pwm_out[4] == $past(channel_polarity_reg[4]))
    else $error("channel 4 level at period restart wrong");
endmodule
`default_nettype wire

// >>> verilog/ppcs_pkg.sv
// Constants and types for the channel polarity and clock source block
// Overview of operation
// - Six start-level bits at positions 5 to 0 set each channel's starting level on its own.
// - A start-level bit of 1 makes the output high at period start and low once duty is reached.
// - A start-level bit of 0 makes the output low at period start and high once duty is reached.
// - Start-level bits read and write at any time and may act mid-period.
// - Channels 0, 1, 4 and 5 take the first prescaled clock on 0 and the first scaled clock on 1.
// - Channels 2 and 3 take the second prescaled clock on 0 and the second scaled clock on 1.
// - Each source choice bit sits at its channel number, a choice between two sources.
// - Source choice bits read and write at any time and may act mid-period.
// - Each prescaled clock is the bus clock over a power of two from 1 to 128, set by 3 bits.
// - A newly enabled channel's waveform starts only at the next tick of its chosen source.
package ppcs_pkg;
  localparam int          NUM_CH          = 6;
  localparam int          RATE_W          = 3;
  localparam int          CNT_W           = 8;
  localparam logic [11:0] ADDR_POLARITY   = 12'h000;
  localparam logic [11:0] ADDR_CLK_SOURCE = 12'h004;
  localparam logic [11:0] ADDR_RATES      = 12'h008;
  localparam logic [11:0] ADDR_ENABLE     = 12'h00C;
  localparam logic [11:0] ADDR_PERIOD0    = 12'h010;
  localparam logic [11:0] ADDR_DUTY0      = 12'h030;
  localparam logic [11:0] ADDR_STATUS     = 12'h050;
  localparam logic [5:0]  CH_MASK         = 6'h3F;
  localparam logic [5:0]  SECOND_GROUP    = 6'h0C;
  localparam int          RATE_B_LSB      = 4;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  localparam logic [6:0]  PRE_RESET       = 7'h00;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [11:0] addr;
  } ppcs_req_t;
endpackage

// >>> verif/pwm_polarity_clock_select_tb.sv
// Self-checking bench for the channel polarity and clock source block
`timescale 1ns/1ns
`default_nettype none
module pwm_polarity_clock_select_tb;
  logic        hclk                = 1'b0;
  logic        hresetn             = 1'b0;
  logic        hsel                = 1'b0;
  logic        hwrite              = 1'b0;
  logic [31:0] haddr               = 32'h0;
  logic [31:0] hwdata              = 32'h0;
  logic [1:0]  htrans              = 2'h0;
  logic [2:0]  hsize               = ppcs_pkg::HSIZE_WORD;
  logic        first_scaled_clock  = 1'b0;
  logic        second_scaled_clock = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [5:0]  pwm_out;
  logic [31:0] rd;
  int          n_start;
  int          n_after;
  int          n_mismatch          = 0;
  int          n_compared          = 0;

  always #5 hclk = ~hclk;

  ppcs_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .first_scaled_clock(first_scaled_clock), .second_scaled_clock(second_scaled_clock),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single AHB-Lite transfer; read data lands in rd
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    hwrite <= wr;
    htrans <= ppcs_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask

  // Poll status until all channels in m run, bounded
  task automatic wait_run(input logic [5:0] m, input int lim);
    int k;
    k = 0;
    do begin
      xfer(1'b0, ppcs_pkg::ADDR_STATUS, 32'h0);
      k++;
    end while ((rd[5:0] & m) !== m && k < lim);
  endtask

  task automatic pulse(input logic second);
    @(posedge hclk);
    if (second) second_scaled_clock <= 1'b1;
    else first_scaled_clock <= 1'b1;
    repeat (6) @(posedge hclk);
    first_scaled_clock  <= 1'b0;
    second_scaled_clock <= 1'b0;
    repeat (6) @(posedge hclk);
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, ppcs_pkg::ADDR_POLARITY, 32'h0);
    chk("polarity at reset", rd, 32'h0);
    // Walk each bit, bit 6 must stay unimplemented
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, ppcs_pkg::ADDR_POLARITY, 32'h1 << i);
      xfer(1'b0, ppcs_pkg::ADDR_POLARITY, 32'h0);
      chk("polarity bit", rd, (i < 6) ? (32'h1 << i) : 32'h0);
      xfer(1'b1, ppcs_pkg::ADDR_CLK_SOURCE, 32'h1 << i);
      xfer(1'b0, ppcs_pkg::ADDR_CLK_SOURCE, 32'h0);
      chk("source bit", rd, (i < 6) ? (32'h1 << i) : 32'h0);
    end
    xfer(1'b1, ppcs_pkg::ADDR_POLARITY, 32'hFFFFFFFF);
    xfer(1'b0, ppcs_pkg::ADDR_POLARITY, 32'h0);
    chk("polarity upper bits", rd, 32'h0000003F);
    xfer(1'b1, 12'h0FC, 32'hFFFFFFFF);
    xfer(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", rd, 32'h0);
    xfer(1'b1, ppcs_pkg::ADDR_RATES, 32'h00000077);
    xfer(1'b0, ppcs_pkg::ADDR_RATES, 32'h0);
    chk("rates", rd, 32'h00000077);
    // Waveforms on prescaled clocks at full rate, duty never reached
    xfer(1'b1, ppcs_pkg::ADDR_RATES, 32'h0);
    xfer(1'b1, ppcs_pkg::ADDR_CLK_SOURCE, 32'h0);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, ppcs_pkg::ADDR_PERIOD0 + 12'(i * 4), 32'h00000008);
      xfer(1'b1, ppcs_pkg::ADDR_DUTY0 + 12'(i * 4), 32'h000000FF);
    end
    xfer(1'b1, ppcs_pkg::ADDR_POLARITY, 32'h0000002D);
    xfer(1'b1, ppcs_pkg::ADDR_ENABLE, 32'h0000003F);
    wait_run(6'h3F, 20);
    chk("status all run", rd, 32'h0000003F);
    repeat (20) @(posedge hclk);
    chk("levels 2D", {26'h0, pwm_out}, 32'h0000002D);
    xfer(1'b1, ppcs_pkg::ADDR_POLARITY, 32'h00000012);
    repeat (5) @(posedge hclk);
    chk("levels 12", {26'h0, pwm_out}, 32'h00000012);
    // Duty of 4 in a period of 8: four cycles at start level, four inverted
    for (int i = 0; i < 6; i++)
      xfer(1'b1, ppcs_pkg::ADDR_DUTY0 + 12'(i * 4), 32'h00000004);
    repeat (10) @(posedge hclk);
    n_start = 0;
    n_after = 0;
    repeat (8) begin
      @(posedge hclk);
      if (pwm_out === 6'h12) n_start++;
      if (pwm_out === 6'h2D) n_after++;
    end
    chk("cycles at start level", n_start, 32'h00000004);
    chk("cycles past duty", n_after, 32'h00000004);
    for (int i = 0; i < 6; i++)
      xfer(1'b1, ppcs_pkg::ADDR_DUTY0 + 12'(i * 4), 32'h000000FF);
    // All channels on scaled clocks: nothing starts until a tick
    xfer(1'b1, ppcs_pkg::ADDR_ENABLE, 32'h0);
    xfer(1'b1, ppcs_pkg::ADDR_CLK_SOURCE, 32'h0000003F);
    xfer(1'b1, ppcs_pkg::ADDR_ENABLE, 32'h0000003F);
    repeat (20) @(posedge hclk);
    xfer(1'b0, ppcs_pkg::ADDR_STATUS, 32'h0);
    chk("status idle scaled", rd, 32'h0);
    pulse(1'b1);
    wait_run(6'h0C, 10);
    chk("status second", rd, 32'h0000000C);
    pulse(1'b0);
    wait_run(6'h3F, 10);
    chk("status first", rd, 32'h0000003F);
    repeat (5) @(posedge hclk);
    chk("levels scaled", {26'h0, pwm_out}, 32'h00000012);
    // Mixed choice: channels 2 and 3 wait for their scaled clock
    xfer(1'b1, ppcs_pkg::ADDR_ENABLE, 32'h0);
    xfer(1'b1, ppcs_pkg::ADDR_CLK_SOURCE, 32'h0000000C);
    xfer(1'b1, ppcs_pkg::ADDR_ENABLE, 32'h0000003F);
    wait_run(6'h33, 10);
    chk("status mixed", rd, 32'h00000033);
    // First prescaler at half rate, second at its slowest: channel 2 starts later
    xfer(1'b1, ppcs_pkg::ADDR_ENABLE, 32'h0);
    xfer(1'b1, ppcs_pkg::ADDR_CLK_SOURCE, 32'h0);
    xfer(1'b1, ppcs_pkg::ADDR_RATES, 32'h00000071);
    xfer(1'b1, ppcs_pkg::ADDR_ENABLE, 32'h00000005);
    xfer(1'b0, ppcs_pkg::ADDR_STATUS, 32'h0);
    chk("status half rate", rd, 32'h00000001);
    wait_run(6'h05, 60);
    chk("status slow rate", rd, 32'h00000005);
    end_sim();
  end

  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end
endmodule
`default_nettype wire
